// ### hdl/fault_regs_pkg.sv
// Shared offsets, field layouts, reset values and carrier types of the fault register bank
package fault_regs_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  localparam logic [7:0] OFS_FAULT_CONTROL            = 8'h00;
  localparam logic [7:0] OFS_FAULT_CONTROL_COMPLEMENT = 8'h01;
  localparam logic [7:0] OFS_SUPPLY_FAULT_STATUS      = 8'h02;
  localparam logic [7:0] OFS_STATUS_CLEAR             = 8'h03;
  localparam logic [7:0] OFS_IRQ_STATUS               = 8'h04;
  localparam logic [7:0] OFS_IRQ_CLEAR                = 8'h05;
  localparam logic [7:0] OFS_IRQ_ENABLE               = 8'h06;

  localparam int CLEAR_POS  = 6;
  localparam int COUNT_LSB  = 2;
  localparam int COUNT_W    = 4;
  localparam int SELECT_LSB = 0;
  localparam int SELECT_W   = 2;

  localparam logic [3:0] COUNT_RESET   = 4'h0;
  localparam logic [3:0] COUNT_CEILING = 4'hF;
  localparam logic [3:0] MAX_SEL_0     = 4'h1;
  localparam logic [3:0] MAX_SEL_1     = 4'h2;
  localparam logic [3:0] MAX_SEL_2     = 4'h6;
  localparam logic [3:0] MAX_SEL_3     = 4'hC;

  localparam logic [1:0] SELECT_RESET        = 2'h0;
  localparam logic [1:0] SELECT_INV_RESET    = 2'h0;
  localparam logic       CLEAR_INV_RESET     = 1'b0;
  localparam logic       CLEAR_PENDING_RESET = 1'b0;

  localparam int          FLAG_COUNT   = 15;
  localparam logic [14:0] STATUS_RESET = 15'h0000;

  localparam int         IRQ_W      = 3;
  localparam int         IRQ_FAULT  = 0;
  localparam int         IRQ_LIMIT  = 1;
  localparam int         IRQ_REJECT = 2;
  localparam logic [2:0] IRQ_RESET  = 3'h0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;

  typedef struct packed {
    logic switcher2_current_limit_flag;
    logic switcher1_current_limit_flag;
    logic thermal_shutdown_flag;
    logic switcher2_undervoltage_flag;
    logic switcher1_undervoltage_flag;
    logic ext_monitor4_undervoltage_flag;
    logic ext_monitor3_undervoltage_flag;
    logic ext_monitor2_undervoltage_flag;
    logic ext_monitor1_undervoltage_flag;
    logic switcher2_overvoltage_flag;
    logic switcher1_overvoltage_flag;
    logic ext_monitor4_overvoltage_flag;
    logic ext_monitor3_overvoltage_flag;
    logic ext_monitor2_overvoltage_flag;
    logic ext_monitor1_overvoltage_flag;
  } supply_faults_t;

  typedef struct packed {
    logic [8:0] reserved;
    logic       fault_count_clear;
    logic [3:0] fault_count_value;
    logic [1:0] fault_count_max_select;
  } fault_control_t;

  typedef struct packed {
    logic [8:0] reserved;
    logic       fault_count_clear_inverse;
    logic [3:0] unused;
    logic [1:0] fault_count_max_select_inverse;
  } fault_control_complement_t;

endpackage

// ### hdl/sticky_flag_bank.sv
// Bank of sticky flags: set by hardware events, cleared by a write-one mask
`timescale 1ns/1ps
module sticky_flag_bank #(
  parameter int WIDTH = 15
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  output logic      [WIDTH-1:0] flags
);
  import fault_regs_pkg::*;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_flag
      // Set wins, so an event landing on the clear cycle survives
      always_ff @(posedge mclk) begin
        if (rst) begin
          flags[i] <= 1'b0;
        end else begin
          flags[i] <= set[i] | (flags[i] & ~clr[i]);
        end
      end
    end
  endgenerate

endmodule

// ### hdl/fault_counter.sv
// Fault error counter saturating at fifteen, with a selectable maximum for the limit flag
`timescale 1ns/1ps
module fault_counter (
  input  wire logic                         mclk,
  input  wire logic                         rst,
  input  wire logic                         clear,
  input  wire logic                         step,
  input  wire logic [fault_regs_pkg::SELECT_W-1:0] max_select,
  output logic      [fault_regs_pkg::COUNT_W-1:0]  count,
  output logic                              at_limit
);
  import fault_regs_pkg::*;

  logic [COUNT_W-1:0] maximum;
  logic [COUNT_W-1:0] next_count;
  logic               can_step;

  assign maximum = (max_select == 2'h0) ? MAX_SEL_0 :
                   (max_select == 2'h1) ? MAX_SEL_1 :
                   (max_select == 2'h2) ? MAX_SEL_2 : MAX_SEL_3;

  assign can_step = step && (count != COUNT_CEILING);

  // A fault arriving with the clear still counts, starting from zero
  assign next_count = clear ? (step ? 4'h1 : COUNT_RESET) :
                      can_step ? count + 4'h1 : count;

  assign at_limit = (count >= maximum);

  always_ff @(posedge mclk) begin
    if (rst) begin
      count <= COUNT_RESET;
    end else begin
      count <= next_count;
    end
  end

endmodule

// ### hdl/fault_counter_status_regs.sv
// Fault control, complement and latched supply fault status registers with interrupt
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module fault_counter_status_regs (
  input  wire logic                           mclk,
  input  wire logic                           rst,
  input  wire fault_regs_pkg::bus_req_t       bus_req,
  output logic      [fault_regs_pkg::DATA_W-1:0] rdata,
  input  wire fault_regs_pkg::supply_faults_t supply_faults,
  input  wire logic                           fault_event,
  output logic                                count_at_limit,
  output logic                                irq
);
  import fault_regs_pkg::*;

  // Address decode
  logic hit_control;
  logic hit_complement;
  logic hit_status;
  logic hit_status_clear;
  logic hit_irq_status;
  logic hit_irq_clear;
  logic hit_irq_enable;

  assign hit_control      = (bus_req.addr == OFS_FAULT_CONTROL);
  assign hit_complement   = (bus_req.addr == OFS_FAULT_CONTROL_COMPLEMENT);
  assign hit_status       = (bus_req.addr == OFS_SUPPLY_FAULT_STATUS);
  assign hit_status_clear = (bus_req.addr == OFS_STATUS_CLEAR);
  assign hit_irq_status   = (bus_req.addr == OFS_IRQ_STATUS);
  assign hit_irq_clear    = (bus_req.addr == OFS_IRQ_CLEAR);
  assign hit_irq_enable   = (bus_req.addr == OFS_IRQ_ENABLE);

  // Write strobes per register
  logic wr_control;
  logic wr_complement;
  logic wr_status_clear;
  logic wr_irq_clear;
  logic wr_irq_enable;

  assign wr_control      = bus_req.wr & hit_control;
  assign wr_complement   = bus_req.wr & hit_complement;
  assign wr_status_clear = bus_req.wr & hit_status_clear;
  assign wr_irq_clear    = bus_req.wr & hit_irq_clear;
  assign wr_irq_enable   = bus_req.wr & hit_irq_enable;

  // Stored control state
  logic [SELECT_W-1:0] max_select;
  logic [SELECT_W-1:0] max_select_inverse;
  logic                clear_inverse;
  logic                clear_pending;
  logic [IRQ_W-1:0]    irq_enable;

  // Write data views
  fault_control_t            wr_ctrl_view;
  fault_control_complement_t wr_comp_view;

  assign wr_ctrl_view = fault_control_t'(bus_req.wdata);
  assign wr_comp_view = fault_control_complement_t'(bus_req.wdata);

  // Protection check against the complement register
  logic select_match;
  logic clear_asked;
  logic clear_match;
  logic take_select;
  logic take_clear;
  logic write_rejected;

  assign select_match = (wr_ctrl_view.fault_count_max_select == ~max_select_inverse);
  assign clear_asked  = wr_ctrl_view.fault_count_clear;
  assign clear_match  = ~clear_inverse;

  assign take_select = wr_control & select_match;
  assign take_clear  = wr_control & clear_asked & clear_match;

  // Mismatch on the select field, or on a clear that is asked for, is reported, never applied
  assign write_rejected = wr_control & (~select_match | (clear_asked & ~clear_match));

  logic [SELECT_W-1:0] next_max_select;

  assign next_max_select = take_select ? wr_ctrl_view.fault_count_max_select : max_select;

  always_ff @(posedge mclk) begin
    if (rst) begin
      max_select <= SELECT_RESET;
    end else begin
      max_select <= next_max_select;
    end
  end

  // Complement register holds only the mirrored bits
  always_ff @(posedge mclk) begin
    if (rst) begin
      max_select_inverse <= SELECT_INV_RESET;
      clear_inverse      <= CLEAR_INV_RESET;
    end else if (wr_complement) begin
      max_select_inverse <= wr_comp_view.fault_count_max_select_inverse;
      clear_inverse      <= wr_comp_view.fault_count_clear_inverse;
    end
  end

  // Clear bit reads 1 for one cycle, then drops as the counter zeroes
  always_ff @(posedge mclk) begin
    if (rst) begin
      clear_pending <= CLEAR_PENDING_RESET;
    end else begin
      clear_pending <= take_clear;
    end
  end

  // Fault error counter
  logic [COUNT_W-1:0] fault_count_value;
  logic               at_limit;

  fault_counter u_counter (
    .mclk       (mclk),
    .rst        (rst),
    .clear      (clear_pending),
    .step       (fault_event),
    .max_select (max_select),
    .count      (fault_count_value),
    .at_limit   (at_limit)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      count_at_limit <= 1'b0;
    end else begin
      count_at_limit <= at_limit;
    end
  end

  // Latched supply faults, cleared by a write-one mask
  logic [FLAG_COUNT-1:0] fault_levels;
  logic [FLAG_COUNT-1:0] status_clear_mask;
  logic [FLAG_COUNT-1:0] status_flags;

  assign fault_levels      = supply_faults;
  assign status_clear_mask = wr_status_clear ? bus_req.wdata[FLAG_COUNT-1:0] :
                                               STATUS_RESET;

  sticky_flag_bank #(
    .WIDTH (FLAG_COUNT)
  ) u_status (
    .mclk  (mclk),
    .rst   (rst),
    .set   (fault_levels),
    .clr   (status_clear_mask),
    .flags (status_flags)
  );

  supply_faults_t status_view;

  assign status_view = supply_faults_t'(status_flags);

  // Interrupt events
  logic             fault_newly_latched;
  logic             limit_rise;
  logic [IRQ_W-1:0] irq_events;
  logic [IRQ_W-1:0] irq_clear_mask;
  logic [IRQ_W-1:0] irq_flags;

  // A fault already latched does not raise a second event
  assign fault_newly_latched = |(fault_levels & ~status_flags);
  assign limit_rise          = at_limit & ~count_at_limit;

  assign irq_events[IRQ_FAULT]  = fault_newly_latched;
  assign irq_events[IRQ_LIMIT]  = limit_rise;
  assign irq_events[IRQ_REJECT] = write_rejected;

  assign irq_clear_mask = wr_irq_clear ? bus_req.wdata[IRQ_W-1:0] : IRQ_RESET;

  sticky_flag_bank #(
    .WIDTH (IRQ_W)
  ) u_irq (
    .mclk  (mclk),
    .rst   (rst),
    .set   (irq_events),
    .clr   (irq_clear_mask),
    .flags (irq_flags)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_enable <= IRQ_RESET;
    end else if (wr_irq_enable) begin
      irq_enable <= bus_req.wdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_flags & irq_enable);
    end
  end

  // Read views
  fault_control_t            ctrl_view;
  fault_control_complement_t comp_view;

  assign ctrl_view.reserved               = 9'h000;
  assign ctrl_view.fault_count_clear      = clear_pending;
  assign ctrl_view.fault_count_value      = fault_count_value;
  assign ctrl_view.fault_count_max_select = max_select;

  assign comp_view.reserved                       = 9'h000;
  assign comp_view.fault_count_clear_inverse      = clear_inverse;
  assign comp_view.unused                         = 4'h0;
  assign comp_view.fault_count_max_select_inverse = max_select_inverse;

  // Read selection; write-only and unmapped addresses read zero
  logic [DATA_W-1:0] read_value;

  assign read_value = hit_control    ? DATA_W'(ctrl_view) :
                      hit_complement ? DATA_W'(comp_view) :
                      hit_status     ? {1'b0, status_view} :
                      hit_irq_status ? {13'h0000, irq_flags} :
                      hit_irq_enable ? {13'h0000, irq_enable} :
                                       16'h0000;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (bus_req.rd) begin
      rdata <= read_value;
    end else begin
      rdata <= 16'h0000;
    end
  end

endmodule

// ### dv/fault_counter_status_regs_checker.sv
// Port-level assertions for the fault counter and supply status register bank
`timescale 1ns/1ps
module fault_counter_status_regs_checker (
  input wire logic                              mclk,
  input wire logic                              rst,
  input wire fault_regs_pkg::bus_req_t          bus_req,
  input wire logic [fault_regs_pkg::DATA_W-1:0] rdata,
  input wire fault_regs_pkg::supply_faults_t    supply_faults,
  input wire logic                              fault_event,
  input wire logic                              count_at_limit,
  input wire logic                              irq
);
  import fault_regs_pkg::*;
  wire rd_ctl = bus_req.rd && bus_req.addr == OFS_FAULT_CONTROL;
  wire rd_sts = bus_req.rd && bus_req.addr == OFS_SUPPLY_FAULT_STATUS;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  chk_reset_quiet: assert property (
    $fell(rst) |-> !irq && !count_at_limit && rdata == 16'h0000)
    else $error("outputs not quiet after reset");
  chk_rdata_idle: assert property (
    !bus_req.rd |=> rdata == 16'h0000)
    else $error("read data without a read");
  // Faults seen two cycles back must already show in the returned status
  chk_status_latch: assert property (
    rd_sts && !$past(rst) |=> rdata[15] == 1'b0
      && (rdata[14:0] & $past(supply_faults, 2)) == $past(supply_faults, 2))
    else $error("status flag missing after fault");
  chk_ctl_layout: assert property (
    rd_ctl |=> rdata[15:7] == 9'h000)
    else $error("control register upper bits set");
  chk_cmpl_layout: assert property (
    bus_req.rd && bus_req.addr == OFS_FAULT_CONTROL_COMPLEMENT
      |=> rdata[15:7] == 9'h000 && rdata[5:2] == 4'h0)
    else $error("complement register unused bits set");
  chk_limit_zero: assert property (
    rd_ctl && !fault_event ##1 rdata[5:2] == 4'h0 |=> !count_at_limit)
    else $error("limit flag with empty counter");
  // Fifteen is above every selectable maximum; a pending clear would zero it first
  chk_limit_full: assert property (
    rd_ctl ##1 rdata[6:2] == 5'h0F |=> count_at_limit)
    else $error("limit flag low with full counter");
  chk_irq_masked: assert property (
    bus_req.wr && bus_req.addr == OFS_IRQ_ENABLE && bus_req.wdata[2:0] == 3'h0 |-> ##2 !irq)
    else $error("interrupt high with all sources masked");
endmodule

bind fault_counter_status_regs fault_counter_status_regs_checker
  fault_counter_status_regs_checker_i (
  .mclk(mclk), .rst(rst), .bus_req(bus_req), .rdata(rdata), .supply_faults(supply_faults),
  .fault_event(fault_event), .count_at_limit(count_at_limit), .irq(irq));

// ### dv/fault_counter_status_regs_test.sv
// Self-checking bench for the fault counter and supply status register bank
`timescale 1ns/1ps
module fault_counter_status_regs_test;
  import fault_regs_pkg::*;
  logic           mclk;
  logic           rst;
  bus_req_t       bus_req;
  logic [15:0]    rdata;
  supply_faults_t supply_faults;
  logic           fault_event;
  logic           count_at_limit;
  logic           irq;
  int             n_errors;
  int             num_checks;
  logic [15:0]    exp_s;
  logic [1:0]     sel;
  logic [3:0]     max_tab [4];

  fault_counter_status_regs fault_counter_status_regs_i (
    .mclk(mclk), .rst(rst), .bus_req(bus_req), .rdata(rdata), .supply_faults(supply_faults),
    .fault_event(fault_event), .count_at_limit(count_at_limit), .irq(irq));

  always #2.5 mclk = ~mclk;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [15:0] exp, input string what);
    @(posedge mclk);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1 check(what, rdata, exp);
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    test_done();
  end

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    bus_req = '0;
    supply_faults = '0;
    fault_event = 1'b0;
    n_errors = 0;
    num_checks = 0;
    max_tab = '{MAX_SEL_0, MAX_SEL_1, MAX_SEL_2, MAX_SEL_3};
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rc(8'(a), 16'h0000, "reset value");
    wr(OFS_IRQ_ENABLE, 16'h0004);
    rc(OFS_IRQ_ENABLE, 16'h0004, "irq enable");
    // Complement still zero, so this limit must be refused
    wr(OFS_FAULT_CONTROL, 16'h0001);
    rc(OFS_FAULT_CONTROL, 16'h0000, "limit kept");
    check("irq reject", {15'h0000, irq}, 16'h0001);
    rc(OFS_IRQ_STATUS, 16'h0004, "irq status");
    wr(OFS_IRQ_ENABLE, 16'h0000);
    rc(OFS_IRQ_ENABLE, 16'h0000, "irq masked");
    check("irq low", {15'h0000, irq}, 16'h0000);
    wr(OFS_IRQ_CLEAR, 16'h0004);
    rc(OFS_IRQ_STATUS, 16'h0000, "irq cleared");
    for (int s = 0; s < 4; s++) begin
      sel = 2'(s);
      wr(OFS_FAULT_CONTROL_COMPLEMENT, {14'h0000, ~sel});
      wr(OFS_FAULT_CONTROL, {9'h000, 1'b1, 4'h0, sel});
      repeat (2) @(posedge mclk);
      rc(OFS_FAULT_CONTROL, {14'h0000, sel}, "count cleared");
      for (int k = 1; k <= 16; k++) begin
        @(posedge mclk);
        fault_event <= 1'b1;
        @(posedge mclk);
        fault_event <= 1'b0;
        @(posedge mclk);
        #1 check("at limit", {15'h0000, count_at_limit}, {15'h0000, 1'(k >= max_tab[s])});
        rc(OFS_FAULT_CONTROL, {10'h000, (k > 15) ? 4'hF : 4'(k), sel}, "count");
      end
    end
    wr(OFS_FAULT_CONTROL_COMPLEMENT, 16'h0040);
    rc(OFS_FAULT_CONTROL_COMPLEMENT, 16'h0040, "complement");
    wr(OFS_FAULT_CONTROL, 16'h0043);
    repeat (2) @(posedge mclk);
    rc(OFS_FAULT_CONTROL, 16'h003F, "clear refused");
    wr(OFS_FAULT_CONTROL_COMPLEMENT, 16'h0000);
    wr(OFS_FAULT_CONTROL, 16'h0003);
    repeat (2) @(posedge mclk);
    rc(OFS_FAULT_CONTROL, 16'h003F, "clear zero");
    // Limit reached while counting, and the refused clear, both left sticky events
    rc(OFS_IRQ_STATUS, 16'h0006, "irq limit reject");
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 0; a < 3; a++) rc(8'(a), 16'h0000, "second reset");
    wr(OFS_IRQ_ENABLE, 16'h0001);
    exp_s = 16'h0000;
    // Cumulative pattern exposes a flag landing in the wrong position
    for (int i = 0; i < FLAG_COUNT; i++) begin
      @(posedge mclk);
      supply_faults <= supply_faults_t'(15'h0001 << i);
      @(posedge mclk);
      supply_faults <= '0;
      exp_s[i] = 1'b1;
      rc(OFS_SUPPLY_FAULT_STATUS, exp_s, "status");
    end
    check("irq fault", {15'h0000, irq}, 16'h0001);
    rc(OFS_IRQ_STATUS, 16'h0001, "irq fault status");
    wr(OFS_SUPPLY_FAULT_STATUS, 16'h0000);
    rc(OFS_SUPPLY_FAULT_STATUS, 16'h7FFF, "status read only");
    wr(OFS_STATUS_CLEAR, 16'h7FFF);
    rc(OFS_SUPPLY_FAULT_STATUS, 16'h0000, "status cleared");
    wr(OFS_IRQ_CLEAR, 16'h0001);
    rc(OFS_IRQ_STATUS, 16'h0000, "irq fault cleared");
    check("irq idle", {15'h0000, irq}, 16'h0000);
    test_done();
  end
endmodule
